// ==== adc_ref_pkg.sv ====
/*
 Constants, register map and carrier types for the reference and
 converter control block. Assumes a 100 MHz system clock and byte
 addressing on a 32-bit AXI4-Lite bus.
*/
// Summary of operation
// - Reference enable bit switches reference on/off
// - Ready reads 0 until reference has settled
// - Regulator variants always read ready as 1
// - Reserved bits 5:4 read zero, write zero
// - Comparator/DAC gain: off, 1x, 2x, 4x
// - Converter gain: off, 1x, 2x, 4x
// - Two gain paths never affect each other
// - Ten-bit successive approximation into result pair
// - Conversion completion raises a wake-capable interrupt
// - Channel select routes one of fourteen sources
// - Positive reference: pin, supply, 2x, 4x
// - Negative reference: pin or ground
// - Three-bit clock select: divided clock or RC
// - Full conversion lasts 11.5 conversion clock periods
// - Divided clocks track system clock; RC does not
// - RC clock period 1.0 to 6.0 us
// - Start bit begins conversion when converter powered
// - Completion clears start, sets flag, writes result
package adc_ref_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_REF_CTRL = 8'h00;
    localparam logic [7:0] OFS_CTRL0 = 8'h04;
    localparam logic [7:0] OFS_CTRL1 = 8'h08;
    localparam logic [7:0] OFS_RES_HIGH = 8'h0c;
    localparam logic [7:0] OFS_RES_LOW = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Decoded register index
    localparam logic [2:0] IDX_REF = 3'h0;
    localparam logic [2:0] IDX_CTRL0 = 3'h1;
    localparam logic [2:0] IDX_CTRL1 = 3'h2;
    localparam logic [2:0] IDX_RESH = 3'h3;
    localparam logic [2:0] IDX_RESL = 3'h4;
    localparam logic [2:0] IDX_STAT = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h7;
    // Reference control fields
    localparam int REF_EN_BIT = 7;
    localparam int REF_RDY_BIT = 6;
    localparam int CD_GAIN_LSB = 2;
    localparam int AD_GAIN_LSB = 0;
    // Converter control 0 fields
    localparam int CHAN_LSB = 2;
    localparam int GO_BIT = 1;
    localparam int PON_BIT = 0;
    // Converter control 1 fields
    localparam int CLKSEL_LSB = 4;
    localparam int NEGREF_BIT = 2;
    localparam int POSREF_LSB = 0;
    // Reset values and field encodings
    localparam logic [7:0] REF_CTRL_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] TRIAL_FIRST = 10'h200;
    localparam logic [1:0] POSREF_4X = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_SETTLE_NS = 1000;
    localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] CONV_HALF_TADS = 5'h17;
    localparam logic [4:0] FIRST_DECIDE = 5'h04;
    localparam logic [4:0] LAST_HALF = 5'h16;

    typedef struct packed {
        logic enable;
        logic [1:0] cmpDacGain;
        logic [1:0] convGain;
    } ref_ctrl_type;

    typedef struct packed {
        logic [2:0] clkSel;
        logic negRef;
        logic [1:0] posRef;
    } conv_cfg_type;
endpackage

// ==== adc_reference_clock_control.sv ====
/*
 Reference control and successive-approximation sequencer with an
 AXI4-Lite register slave. Assumes the comparator output and the RC
 conversion clock arrive asynchronously from the analog macro, and
 that the trial code drives the DAC of that macro.
*/
`timescale 1ns/1ns
module adc_reference_clock_control #(
    parameter bit HAS_LDO = 1'b0,
    parameter bit LOW_VOLTAGE = 1'b0,
    parameter int unsigned REF_SETTLE_CYCLES = adc_ref_pkg::REF_SETTLE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Analog macro
    input wire logic cmpIn,
    input wire logic rcClkIn,
    output adc_ref_pkg::ref_ctrl_type refCtrl,
    output adc_ref_pkg::conv_cfg_type convCfg,
    output logic [4:0] channelSelect,
    output logic sampleHold,
    output logic [9:0] trialCode,
    output logic convDoneIrq
);
    typedef enum logic {IDLE, CONVERT} conv_state_type;

    function automatic logic [2:0] decodeIdx(input logic [7:0] a);
        if (a == adc_ref_pkg::OFS_REF_CTRL) begin
            return adc_ref_pkg::IDX_REF;
        end else if (a == adc_ref_pkg::OFS_CTRL0) begin
            return adc_ref_pkg::IDX_CTRL0;
        end else if (a == adc_ref_pkg::OFS_CTRL1) begin
            return adc_ref_pkg::IDX_CTRL1;
        end else if (a == adc_ref_pkg::OFS_RES_HIGH) begin
            return adc_ref_pkg::IDX_RESH;
        end else if (a == adc_ref_pkg::OFS_RES_LOW) begin
            return adc_ref_pkg::IDX_RESL;
        end else if (a == adc_ref_pkg::OFS_STATUS) begin
            return adc_ref_pkg::IDX_STAT;
        end else begin
            return adc_ref_pkg::IDX_NONE;
        end
    endfunction

    // Half a conversion clock period in system clocks
    function automatic logic [5:0] halfLen(input logic [2:0] sel);
        case (sel)
            3'h0: return 6'h01;
            3'h4: return 6'h02;
            3'h1: return 6'h04;
            3'h5: return 6'h08;
            3'h2: return 6'h10;
            default: return 6'h20;
        endcase
    endfunction

    adc_ref_pkg::ref_ctrl_type refCtrl_r;
    adc_ref_pkg::conv_cfg_type convCfg_r;
    conv_state_type state_r;
    logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
    logic [7:0] awAddr_r;
    logic [7:0] wData_r;
    logic wStrb0_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic doWrite;
    logic [2:0] wrIdx;
    logic [4:0] chanSel_r;
    logic goBusy_r, powerOn_r, doneFlag_r, refRdy_r;
    logic [31:0] settleCnt_r;
    logic [9:0] result_r, trial_r;
    logic [3:0] bitPos_r;
    logic [4:0] halfIdx_r;
    logic [5:0] divCnt_r;
    logic cmpS1, cmpS2, rcS1, rcS2, rcS3;
    logic rcMode, rcEdge, halfTick, decide, convDone, refReadyBit;
    logic [7:0] regRef, regCtrl0, regCtrl1;

    // Write channels are taken independently, committed once both are held
    assign awready = !awHeld_r && !bvalid_r;
    assign wready = !wHeld_r && !bvalid_r;
    assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
    assign wrIdx = decodeIdx(awAddr_r);
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
        end else if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wHeld_r <= 1'b0;
            wData_r <= 8'h00;
            wStrb0_r <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata[7:0];
            wStrb0_r <= wstrb[0];
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= adc_ref_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid_r <= 1'b1;
            if (wrIdx == adc_ref_pkg::IDX_NONE) begin
                bresp_r <= adc_ref_pkg::RESP_SLVERR;
            end else begin
                bresp_r <= adc_ref_pkg::RESP_OKAY;
            end
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Register images; reserved bits are constant zero
    assign refReadyBit = HAS_LDO ? 1'b1 : refRdy_r;
    assign regRef = {refCtrl_r.enable, refReadyBit, 2'b00, refCtrl_r.cmpDacGain,
                     refCtrl_r.convGain};
    assign regCtrl0 = {1'b0, chanSel_r, goBusy_r, powerOn_r};
    assign regCtrl1 = {1'b0, convCfg_r.clkSel, 1'b0, convCfg_r.negRef, convCfg_r.posRef};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= adc_ref_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= adc_ref_pkg::RESP_OKAY;
            if (decodeIdx(araddr) == adc_ref_pkg::IDX_REF) begin
                rdata_r <= {24'h000000, regRef};
            end else if (decodeIdx(araddr) == adc_ref_pkg::IDX_CTRL0) begin
                rdata_r <= {24'h000000, regCtrl0};
            end else if (decodeIdx(araddr) == adc_ref_pkg::IDX_CTRL1) begin
                rdata_r <= {24'h000000, regCtrl1};
            end else if (decodeIdx(araddr) == adc_ref_pkg::IDX_RESH) begin
                rdata_r <= {30'h0, result_r[9:8]};
            end else if (decodeIdx(araddr) == adc_ref_pkg::IDX_RESL) begin
                rdata_r <= {24'h000000, result_r[7:0]};
            end else if (decodeIdx(araddr) == adc_ref_pkg::IDX_STAT) begin
                rdata_r <= {31'h0, doneFlag_r};
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= adc_ref_pkg::RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Reference control; each gain field lands only in its own path
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            refCtrl_r <= adc_ref_pkg::REF_CTRL_RST[4:0];
        end else if (doWrite && wStrb0_r && wrIdx == adc_ref_pkg::IDX_REF) begin
            refCtrl_r.enable <= wData_r[adc_ref_pkg::REF_EN_BIT];
            refCtrl_r.cmpDacGain <= wData_r[adc_ref_pkg::CD_GAIN_LSB +: 2];
            refCtrl_r.convGain <= wData_r[adc_ref_pkg::AD_GAIN_LSB +: 2];
        end
    end

    // Settle counter; disable drops ready at once
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            settleCnt_r <= 32'h0000_0000;
            refRdy_r <= 1'b0;
        end else if (!refCtrl_r.enable) begin
            settleCnt_r <= 32'h0000_0000;
            refRdy_r <= 1'b0;
        end else if (settleCnt_r == 32'(REF_SETTLE_CYCLES)) begin
            refRdy_r <= 1'b1;
        end else begin
            settleCnt_r <= settleCnt_r + 32'h0000_0001;
        end
    end

    // Converter configuration
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            convCfg_r <= 6'h00;
            chanSel_r <= 5'h00;
            powerOn_r <= 1'b0;
        end else if (doWrite && wStrb0_r) begin
            if (wrIdx == adc_ref_pkg::IDX_CTRL0) begin
                chanSel_r <= wData_r[adc_ref_pkg::CHAN_LSB +: 5];
                powerOn_r <= wData_r[adc_ref_pkg::PON_BIT];
            end else if (wrIdx == adc_ref_pkg::IDX_CTRL1) begin
                convCfg_r.clkSel <= wData_r[adc_ref_pkg::CLKSEL_LSB +: 3];
                convCfg_r.negRef <= wData_r[adc_ref_pkg::NEGREF_BIT];
                // 4x is not offered on low-voltage parts; such a value leaves posRef unchanged, clkSel and negRef still land
                if (!(LOW_VOLTAGE && wData_r[adc_ref_pkg::POSREF_LSB +: 2] ==
                      adc_ref_pkg::POSREF_4X)) begin
                    convCfg_r.posRef <= wData_r[adc_ref_pkg::POSREF_LSB +: 2];
                end
            end
        end
    end

    // Start bit: software sets while powered, hardware clears on completion
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            goBusy_r <= 1'b0;
        end else if (doWrite && wStrb0_r && wrIdx == adc_ref_pkg::IDX_CTRL0) begin
            goBusy_r <= wData_r[adc_ref_pkg::GO_BIT] && powerOn_r;
        end else if (convDone || !powerOn_r) begin
            goBusy_r <= 1'b0;
        end
    end

    // Done flag: completion wins over a same-cycle clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            doneFlag_r <= 1'b0;
        end else if (convDone) begin
            doneFlag_r <= 1'b1;
        end else if (doWrite && wStrb0_r && wrIdx == adc_ref_pkg::IDX_STAT && wData_r[0]) begin
            doneFlag_r <= 1'b0;
        end
    end

    // Asynchronous analog inputs; stage one feeds stage two only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmpS1 <= 1'b0;
            cmpS2 <= 1'b0;
            rcS1 <= 1'b0;
            rcS2 <= 1'b0;
            rcS3 <= 1'b0;
        end else begin
            cmpS1 <= cmpIn;
            cmpS2 <= cmpS1;
            rcS1 <= rcClkIn;
            rcS2 <= rcS1;
            rcS3 <= rcS2;
        end
    end

    // RC ticks are free of the system divider; each RC edge is half a period
    assign rcMode = convCfg_r.clkSel[1:0] == 2'b11;
    assign rcEdge = rcS2 ^ rcS3;
    assign halfTick = (state_r == CONVERT) &&
                      (rcMode ? rcEdge : (divCnt_r == halfLen(convCfg_r.clkSel) - 6'h01));
    assign decide = halfTick && halfIdx_r >= adc_ref_pkg::FIRST_DECIDE && !halfIdx_r[0];
    assign convDone = halfTick && halfIdx_r == adc_ref_pkg::LAST_HALF;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt_r <= 6'h00;
        end else if (state_r != CONVERT || halfTick) begin
            divCnt_r <= 6'h00;
        end else begin
            divCnt_r <= divCnt_r + 6'h01;
        end
    end

    // Sequencer; software clearing the start bit aborts without a result
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= IDLE;
            halfIdx_r <= 5'h00;
            trial_r <= adc_ref_pkg::TRIAL_FIRST;
            bitPos_r <= 4'h9;
        end else begin
            case (state_r)
                IDLE: begin
                    halfIdx_r <= 5'h00;
                    trial_r <= adc_ref_pkg::TRIAL_FIRST;
                    bitPos_r <= 4'h9;
                    if (goBusy_r && powerOn_r) begin
                        state_r <= CONVERT;
                    end
                end
                CONVERT: begin
                    if (!goBusy_r || convDone) begin
                        state_r <= IDLE;
                    end else if (halfTick) begin
                        halfIdx_r <= halfIdx_r + 5'h01;
                        if (decide) begin
                            trial_r[bitPos_r] <= cmpS2;
                            trial_r[bitPos_r - 4'h1] <= 1'b1;
                            bitPos_r <= bitPos_r - 4'h1;
                        end
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_r <= adc_ref_pkg::RESULT_RST;
        end else if (convDone && goBusy_r) begin
            result_r <= {trial_r[9:1], cmpS2};
        end
    end

    // Gains pass straight to the analog paths
    assign refCtrl = refCtrl_r;
    assign convCfg = convCfg_r;
    assign channelSelect = chanSel_r;
    assign sampleHold = powerOn_r && state_r == IDLE;
    assign trialCode = trial_r;
    assign convDoneIrq = doneFlag_r;

    AST_READY_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !refCtrl_r.enable |=> !refRdy_r) else $error("ready while disabled");
    AST_READY_LATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(refRdy_r) |-> $past(refCtrl_r.enable) &&
        settleCnt_r == 32'(REF_SETTLE_CYCLES)) else $error("ready early");
    AST_RSVD_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        arvalid && arready && araddr == adc_ref_pkg::OFS_REF_CTRL |=>
        rdata_r[5:4] == 2'b00 && rdata_r[6] == (HAS_LDO ? 1'b1 : $past(refRdy_r)))
        else $error("bad reference read");
    AST_GAIN_SPLIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        doWrite && wStrb0_r && wrIdx == adc_ref_pkg::IDX_REF |=>
        refCtrl_r.convGain == $past(wData_r[1:0]) &&
        refCtrl_r.cmpDacGain == $past(wData_r[3:2]) &&
        refCtrl_r.enable == $past(wData_r[7])) else $error("gain write lost");
    AST_NO_START_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_r == IDLE && !powerOn_r |=> state_r == IDLE)
        else $error("start while off");
    AST_DONE_SEQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        convDone && goBusy_r |=> state_r == IDLE && doneFlag_r && !goBusy_r &&
        result_r == {$past(trial_r[9:1]), $past(cmpS2)}) else $error("completion");
    AST_FAST_TICK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_r == CONVERT && convCfg_r.clkSel == 3'h0 |-> halfTick)
        else $error("fosc/2 tick missing");
    AST_RC_TICK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rcMode && halfTick |-> rcEdge) else $error("rc tick from divider");
    AST_LENGTH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(state_r == CONVERT) && convCfg_r.clkSel == 3'h0 |-> ##22 (convDone || !goBusy_r))
        else $error("length not 11.5");
endmodule

// ==== tb.sv ====
/*
 Self-checking bench for the reference and converter control block.
 Assumes the AXI4-Lite slave, register map and conversion timing of the
 package; the bench drives every port itself.
*/
`timescale 1ns/1ns
module tb;
    localparam int SETTLE = 20;
    localparam int RC_HALF = 80;
    localparam int TIMEOUT_CYC = 20000;
    localparam logic [7:0] A_REF = adc_ref_pkg::OFS_REF_CTRL;
    localparam logic [7:0] A_C0 = adc_ref_pkg::OFS_CTRL0;
    localparam logic [7:0] A_C1 = adc_ref_pkg::OFS_CTRL1;
    localparam logic [7:0] A_RH = adc_ref_pkg::OFS_RES_HIGH;
    localparam logic [7:0] A_RL = adc_ref_pkg::OFS_RES_LOW;
    localparam logic [7:0] A_ST = adc_ref_pkg::OFS_STATUS;
    localparam int HALF [6] = '{1, 2, 4, 8, 16, 32};
    localparam logic [2:0] SEL [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    logic ref_clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cmpIn, rcClkIn, sampleHold, convDoneIrq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, gv;
    logic [2:0] sv;
    logic [7:0] v;
    logic [4:0] channelSelect;
    logic [9:0] trialCode;
    adc_ref_pkg::ref_ctrl_type refCtrl;
    adc_ref_pkg::conv_cfg_type convCfg;
    logic rcRun;
    int rcCnt, cycleCount, errCount, checkCount, n0, nn;

    adc_reference_clock_control #(.REF_SETTLE_CYCLES(SETTLE)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cmpIn(cmpIn), .rcClkIn(rcClkIn), .refCtrl(refCtrl), .convCfg(convCfg),
        .channelSelect(channelSelect), .sampleHold(sampleHold),
        .trialCode(trialCode), .convDoneIrq(convDoneIrq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // RC clock only runs while a conversion on it is under way
    always @(posedge ref_clk) begin
        if (rcRun && rcCnt == RC_HALF - 1) begin
            rcCnt <= 0;
            rcClkIn <= ~rcClkIn;
        end else begin
            rcCnt <= rcRun ? rcCnt + 1 : 0;
        end
    end

    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == TIMEOUT_CYC) begin
            errCount++;
            $display("CHECK FAILED at %0t: run took too long", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Bounded waits; a hung handshake is a mismatch, not a hang
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        int n;
        logic awDone, wDone;
        n = 0;
        awDone = 1'b0;
        wDone = 1'b0;
        resp = 2'h3;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        while (!(awDone && wDone) && n < 100) begin
            @(posedge ref_clk);
            n++;
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (n < 200) begin
            @(posedge ref_clk);
            n++;
            if (bvalid === 1'b1) begin
                resp = bresp;
                break;
            end
        end
        check_val(32'(n < 200), 32'h1, "write handshake");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        d = 32'hx;
        resp = 2'h3;
        arvalid <= 1'b1;
        araddr <= a;
        while (n < 100) begin
            @(posedge ref_clk);
            n++;
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
                break;
            end
        end
        while (n < 200) begin
            @(posedge ref_clk);
            n++;
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                break;
            end
        end
        check_val(32'(n < 200), 32'h1, "read handshake");
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check_val({30'h0, r}, {30'h0, adc_ref_pkg::RESP_OKAY}, "write response");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check_val({30'h0, r}, {30'h0, adc_ref_pkg::RESP_OKAY}, "read response");
        check_val(d, exp, "register value");
    endtask

    // Power on, then start in a separate write, then count to completion
    task automatic run_conv(input logic [2:0] sel, output int n);
        wr_ok(A_C1, {1'b0, sel, 4'h0});
        wr_ok(A_C0, 8'h35);
        check_val({31'h0, sampleHold}, 32'h1, "acquiring while powered");
        repeat (SETTLE) @(posedge ref_clk);
        rcRun <= (sel[1:0] == 2'b11);
        wr_ok(A_C0, 8'h37);
        n = 0;
        while (convDoneIrq !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        rcRun <= 1'b0;
    endtask

    initial begin
        {awvalid, wvalid, arvalid, cmpIn, rcClkIn, rcRun} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        bready = 1'b1;
        rready = 1'b1;
        arst_n = 1'b0;
        {rcCnt, cycleCount, errCount, checkCount} = '0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk(A_REF, 32'h0);
        check_val({27'h0, refCtrl}, 32'h0, "reference port after reset");
        check_val({22'h0, trialCode}, {22'h0, adc_ref_pkg::TRIAL_FIRST}, "idle trial code");
        wr_ok(A_REF, 8'h8f);
        check_val({31'h0, refCtrl.enable}, 32'h1, "reference on");
        rd_chk(A_REF, 32'h8f);
        repeat (SETTLE + 4) @(posedge ref_clk);
        rd_chk(A_REF, 32'hcf);
        wr_ok(A_REF, 8'h0f);
        rd_chk(A_REF, 32'h0f);
        for (int g = 0; g < 4; g++) begin
            gv = 2'(g);
            wr_ok(A_REF, {4'h8, gv, ~gv});
            check_val({30'h0, refCtrl.cmpDacGain}, {30'h0, gv}, "cmp gain");
            check_val({30'h0, refCtrl.convGain}, {30'h0, ~gv}, "conv gain");
        end
        for (int i = 0; i < 8; i++) begin
            sv = 3'(i);
            v = {1'b0, sv, 1'b0, sv[0], sv[1:0]};
            wr_ok(A_C1, v);
            rd_chk(A_C1, {24'h0, v});
            check_val({26'h0, convCfg}, {26'h0, sv, sv[0], sv[1:0]}, "cfg port");
        end
        wr_ok(A_C0, 8'h34);
        check_val({27'h0, channelSelect}, 32'd13, "channel port");
        check_val({31'h0, sampleHold}, 32'h0, "no acquire while off");
        wr_ok(A_C0, 8'h36);
        rd_chk(A_C0, 32'h34);
        // Difference against divide-by-2 cancels the fixed start-up latency
        for (int i = 0; i < 6; i++) begin
            cmpIn <= (i % 2 == 0);
            run_conv(SEL[i], nn);
            if (i == 0) n0 = nn;
            check_val(32'(nn - n0), 32'(int'(adc_ref_pkg::CONV_HALF_TADS) * (HALF[i] - 1)),
                      "conversion length");
            rd_chk(A_RL, (i % 2 == 0) ? 32'hff : 32'h0);
            rd_chk(A_RH, (i % 2 == 0) ? 32'h3 : 32'h0);
            rd_chk(A_C0, 32'h35);
            rd_chk(A_ST, 32'h1);
            wr_ok(A_ST, 8'h01);
            check_val({31'h0, convDoneIrq}, 32'h0, "done cleared");
        end
        for (int i = 0; i < 2; i++) begin
            cmpIn <= 1'b0;
            run_conv({i[0], 2'b11}, nn);
            check_val(32'(nn >= 22 * RC_HALF && nn <= 24 * RC_HALF), 32'h1, "rc length");
            rd_chk(A_ST, 32'h1);
            wr_ok(A_ST, 8'h01);
        end
        cmpIn <= 1'b1;
        wr_ok(A_C0, 8'h37);
        repeat (100) @(posedge ref_clk);
        wr_ok(A_C0, 8'h35);
        repeat (800) @(posedge ref_clk);
        rd_chk(A_ST, 32'h0);
        wr_ok(A_RL, 8'haa);
        rd_chk(A_RL, 32'h0);
        // Second reset in mid-run must clear the reference control again
        wr_ok(A_REF, 8'h85);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check_val({27'h0, refCtrl}, 32'h0, "reference port after reset");
        rd_chk(A_REF, 32'h0);
        axi_read(8'h18, rdv, rsp);
        check_val({30'h0, rsp}, {30'h0, adc_ref_pkg::RESP_SLVERR}, "unmapped read response");
        check_val(rdv, 32'h0, "unmapped read data");
        axi_write(8'h1c, 8'h55, rsp);
        check_val({30'h0, rsp}, {30'h0, adc_ref_pkg::RESP_SLVERR}, "unmapped write response");
        report_and_stop();
    end
endmodule
